/* File: osmc_core.sv */
// Search arbitration and scratchpad command logic with its slot event buffer
`default_nettype none

module osmc_buffer #(
  parameter int WIDTH = osmc_pkg::BUF_W,
  parameter int DEPTH = osmc_pkg::BUF_DEPTH
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  import osmc_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("osmc_buffer: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } osmc_buf_t;

  osmc_buf_t        s_q;
  osmc_buf_t        s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (s_q.cnt != (AW + 1)'(DEPTH));
  assign out_valid_out = (s_q.cnt != '0);
  assign out_data_out  = mem[s_q.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[s_q.wp] <= in_data_in;
    end
  end
endmodule // osmc_buffer

module osmc_core #(
  parameter logic [7:0]  FAMILY_CODE   = osmc_pkg::FAMILY_DEF,
  parameter logic [47:0] SERIAL_NUMBER = osmc_pkg::SERIAL_DEF,
  parameter int          NV_PROG_CYCLES = osmc_pkg::NV_PROG_CYC
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic ev_valid_in,
  input  wire logic ev_reset_in,
  input  wire logic ev_bit_in,
  output logic      ev_ready_out,
  output logic      resp_bit_out,
  output logic      selected_out,
  output logic      nonvolatile_busy_flag_out
);
  import osmc_pkg::*;

  // Family code value is arbitrary
  localparam logic [63:0] ROM_ID = {osmc_crc56({SERIAL_NUMBER, FAMILY_CODE}),
                                    SERIAL_NUMBER, FAMILY_CODE};

  initial begin
    if (NV_PROG_CYCLES < 1 || NV_PROG_CYCLES >= (1 << BUSY_W)) begin
      $error("osmc_core: NV_PROG_CYCLES out of range");
    end
  end

  typedef struct packed {
    osmc_state_t       st;
    logic [2:0]        bitcnt;
    logic [1:0]        phase;
    logic [5:0]        idx;
    logic [7:0]        cmd;
    logic [7:0]        sh;
    logic [6:0]        addr;
    logic [7:0]        crc;
    logic [4:0]        cp_idx;
    logic              tx;
    logic [BUSY_W-1:0] busy_cnt;
  } osmc_core_t;

  localparam osmc_core_t CORE_RESET = '{st: OSMC_PASSIVE, tx: 1'b1, default: '0};

  osmc_core_t s_q;
  osmc_core_t s_d;

  logic [7:0] sp   [SP_BYTES];
  logic [7:0] nv1  [24];
  logic [7:0] nv2  [8];
  logic [7:0] sram [8];

  logic       ev_valid;
  logic [1:0] ev_data;
  logic       pop;
  logic       ev_is_reset;
  logic       b;
  logic [7:0] byte_in;
  logic       sp_we;
  logic       copy_we;

  // Unused bytes of a page read as ones and ignore writes
  function automatic logic sp_valid(input logic [6:0] a);
    unique case (a[6:5])
      2'd0:    sp_valid = (a[4:0] < LEN_PAGE1);
      2'd1:    sp_valid = (a[4:0] < LEN_SMALL);
      2'd2:    sp_valid = (a[4:0] < LEN_SMALL);
      default: sp_valid = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] sp_byte(input logic [6:0] a);
    sp_byte = sp_valid(a) ? sp[a] : ONES_BYTE;
  endfunction

  function automatic logic [4:0] copy_len(input logic [7:0] c);
    copy_len = (c == CMD_SP1_NV1 || c == CMD_NV1_SP1) ? LEN_PAGE1 : LEN_SMALL;
  endfunction

  function automatic logic to_eeprom(input logic [7:0] c);
    to_eeprom = (c == CMD_SP1_NV1) || (c == CMD_SP2_NV2);
  endfunction

  // Slot stream is buffered so a copy burst never drops a slot
  osmc_buffer #(
    .WIDTH (BUF_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk_in       (mclk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (ev_valid_in),
    .in_data_in    ({ev_reset_in, ev_bit_in}),
    .in_ready_out  (ev_ready_out),
    .out_valid_out (ev_valid),
    .out_data_out  (ev_data),
    .out_ready_in  (s_q.st != OSMC_COPY)
  );

  assign pop         = ev_valid && (s_q.st != OSMC_COPY);
  assign ev_is_reset = ev_data[1];
  assign b           = ev_data[0];
  assign byte_in     = {b, s_q.sh[7:1]};

  assign resp_bit_out              = s_q.tx;
  assign selected_out              = (s_q.st != OSMC_PASSIVE);
  assign nonvolatile_busy_flag_out = (s_q.busy_cnt != '0) ||
                                     (s_q.st == OSMC_COPY && to_eeprom(s_q.cmd));

  always_comb begin
    s_d     = s_q;
    sp_we   = 1'b0;
    copy_we = 1'b0;
    if (s_q.busy_cnt != '0) begin
      s_d.busy_cnt = s_q.busy_cnt - 1'b1;
    end
    if (pop && ev_is_reset) begin
      // Reset pulse restarts any pass and re-arms deselected logic
      s_d.st     = OSMC_ROMCMD;
      s_d.bitcnt = '0;
      s_d.tx     = 1'b1;
    end else if (s_q.st == OSMC_COPY) begin
      copy_we    = 1'b1;
      s_d.cp_idx = s_q.cp_idx + 1'b1;
      if (s_q.cp_idx == copy_len(s_q.cmd) - 1'b1) begin
        s_d.st = OSMC_PASSIVE;
        if (to_eeprom(s_q.cmd)) begin
          s_d.busy_cnt = BUSY_W'(NV_PROG_CYCLES);
        end
      end
    end else if (pop) begin
      unique case (s_q.st)
        OSMC_PASSIVE: begin
          s_d.tx = 1'b1;
        end
        OSMC_ROMCMD: begin
          s_d.sh     = byte_in;
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          if (s_q.bitcnt == 3'd7) begin
            if (byte_in == CMD_SEARCH) begin
              s_d.st    = OSMC_SEARCH;
              s_d.idx   = '0;
              s_d.phase = 2'd0;
              s_d.tx    = ROM_ID[0];
            end else begin
              s_d.st = OSMC_PASSIVE;
            end
          end
        end
        OSMC_SEARCH: begin
          unique case (s_q.phase)
            2'd0: begin
              s_d.phase = 2'd1;
              s_d.tx    = ~ROM_ID[s_q.idx];
            end
            2'd1: begin
              s_d.phase = 2'd2;
              s_d.tx    = 1'b1;
            end
            default: begin
              s_d.phase = 2'd0;
              if (b != ROM_ID[s_q.idx]) begin
                s_d.st = OSMC_PASSIVE;
                s_d.tx = 1'b1;
              end else if (s_q.idx == 6'(ROM_BITS - 1)) begin
                s_d.st     = OSMC_MEMCMD;
                s_d.bitcnt = '0;
                s_d.tx     = 1'b1;
              end else begin
                s_d.idx = s_q.idx + 1'b1;
                s_d.tx  = ROM_ID[s_q.idx + 1'b1];
              end
            end
          endcase
        end
        OSMC_MEMCMD: begin
          s_d.sh     = byte_in;
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          if (s_q.bitcnt == 3'd7) begin
            s_d.cmd    = byte_in;
            s_d.cp_idx = '0;
            unique case (byte_in)
              CMD_RD_SP, CMD_WR_SP: s_d.st = OSMC_ADDR;
              CMD_SP1_NV1, CMD_SP2_NV2, CMD_SP3_SRAM, CMD_NV1_SP1: begin
                s_d.st = OSMC_COPY;
              end
              default: s_d.st = OSMC_PASSIVE;
            endcase
          end
        end
        OSMC_ADDR: begin
          s_d.sh     = byte_in;
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          if (s_q.bitcnt == 3'd7) begin
            s_d.addr = byte_in[6:0];
            s_d.crc  = '0;
            if (byte_in > ADDR_LAST) begin
              s_d.st = OSMC_PASSIVE;
            end else if (s_q.cmd == CMD_RD_SP) begin
              s_d.st = OSMC_RD;
              s_d.sh = sp_byte(byte_in[6:0]);
              s_d.tx = s_d.sh[0];
            end else begin
              s_d.st = OSMC_WR;
            end
          end
        end
        OSMC_RD: begin
          s_d.crc    = osmc_crc_bit(s_q.crc, s_q.sh[0]);
          s_d.sh     = {1'b1, s_q.sh[7:1]};
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          if (s_q.bitcnt == 3'd7) begin
            if (s_q.addr[4:0] == PAGE_LAST_OFS) begin
              s_d.st = OSMC_CRCOUT;
              s_d.sh = s_d.crc;
            end else begin
              s_d.addr = s_q.addr + 1'b1;
              s_d.sh   = sp_byte(s_q.addr + 1'b1);
            end
          end
          s_d.tx = s_d.sh[0];
        end
        OSMC_CRCOUT: begin
          s_d.sh     = {1'b1, s_q.sh[7:1]};
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          if (s_q.bitcnt == 3'd7) begin
            s_d.st = OSMC_PASSIVE;
            s_d.tx = 1'b1;
          end else begin
            s_d.tx = s_d.sh[0];
          end
        end
        OSMC_WR: begin
          s_d.sh     = byte_in;
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          if (s_q.bitcnt == 3'd7) begin
            sp_we = sp_valid(s_q.addr);
            if (s_q.addr[4:0] == PAGE_LAST_OFS) begin
              s_d.st = OSMC_PASSIVE;
            end else begin
              s_d.addr = s_q.addr + 1'b1;
            end
          end
        end
        default: begin
          s_d.st = OSMC_PASSIVE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // EEPROM and SRAM change only by copy; no bus path reads them directly
  always_ff @(posedge mclk_in) begin
    if (sp_we) begin
      sp[s_q.addr] <= byte_in;
    end
    if (copy_we) begin
      unique case (s_q.cmd)
        CMD_SP1_NV1:  nv1[s_q.cp_idx] <= sp[{2'b00, s_q.cp_idx}];
        CMD_SP2_NV2:  nv2[s_q.cp_idx[2:0]] <= sp[PAGE2_BASE + {2'b00, s_q.cp_idx}];
        CMD_SP3_SRAM: sram[s_q.cp_idx[2:0]] <= sp[PAGE3_BASE + {2'b00, s_q.cp_idx}];
        default:      sp[{2'b00, s_q.cp_idx}] <= nv1[s_q.cp_idx];
      endcase
    end
  end
endmodule // osmc_core
`default_nettype wire

/* File: osmc_pkg.sv */
// Constants, types and helper functions for the search and memory command block
`default_nettype none
package osmc_pkg;
  localparam int          CLK_MHZ         = 200;
  localparam int          NV_PROG_TIME_US = 2000;
  localparam int          NV_PROG_CYC     = NV_PROG_TIME_US * CLK_MHZ;
  localparam int          BUSY_W          = 20;
  localparam int          ROM_BITS        = 64;
  localparam int          SP_BYTES        = 96;
  localparam int          BUF_W           = 2;
  localparam int          BUF_DEPTH       = 2;
  localparam logic [7:0]  FAMILY_DEF      = 8'h5A; // Arbitrary value
  localparam logic [47:0] SERIAL_DEF      = 48'h0000_1234_5678;
  localparam logic [7:0]  CMD_SEARCH      = 8'hF0;
  localparam logic [7:0]  CMD_RD_SP       = 8'h11;
  localparam logic [7:0]  CMD_WR_SP       = 8'h17;
  localparam logic [7:0]  CMD_SP1_NV1     = 8'h22;
  localparam logic [7:0]  CMD_SP2_NV2     = 8'h25;
  localparam logic [7:0]  CMD_SP3_SRAM    = 8'h28;
  localparam logic [7:0]  CMD_NV1_SP1     = 8'h71;
  localparam logic [7:0]  ADDR_LAST       = 8'h5F;
  localparam logic [6:0]  PAGE2_BASE      = 7'h20;
  localparam logic [6:0]  PAGE3_BASE      = 7'h40;
  localparam logic [4:0]  PAGE_LAST_OFS   = 5'h1F;
  localparam logic [4:0]  LEN_PAGE1       = 5'h18;
  localparam logic [4:0]  LEN_SMALL       = 5'h08;
  localparam logic [7:0]  CRC_POLY_REFL   = 8'h8C;
  localparam logic [7:0]  ONES_BYTE       = 8'hFF;

  typedef enum logic [3:0] {
    OSMC_PASSIVE, OSMC_ROMCMD, OSMC_SEARCH, OSMC_MEMCMD, OSMC_ADDR,
    OSMC_RD, OSMC_CRCOUT, OSMC_WR, OSMC_COPY
  } osmc_state_t;

  // One shift step of the reflected x^8+x^5+x^4+1 generator
  function automatic logic [7:0] osmc_crc_bit(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    osmc_crc_bit = {1'b0, crc[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
  endfunction

  function automatic logic [7:0] osmc_crc56(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = osmc_crc_bit(c, d[i]);
    end
    osmc_crc56 = c;
  endfunction
endpackage
`default_nettype wire

/* File: osmc_core_chk.sv */
// Port assertions for the search and memory command core
`default_nettype none
module osmc_core_chk #(
  parameter int NV_PROG_CYCLES = osmc_pkg::NV_PROG_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ev_valid_in,
  input wire logic ev_reset_in,
  input wire logic ev_bit_in,
  input wire logic ev_ready_out,
  input wire logic resp_bit_out,
  input wire logic selected_out,
  input wire logic nonvolatile_busy_flag_out
);
  int busy_cnt_q;
  int busy_cnt_d;
  always_comb busy_cnt_d = nonvolatile_busy_flag_out ? busy_cnt_q + 1 : 0;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  AST_PASSIVE_RELEASE: assert property (!selected_out [*2] |-> resp_bit_out)
    else $error("line pulled low while not selected");
  AST_SELECT_CAUSE: assert property ($rose(selected_out) |-> $past(ev_valid_in && ev_ready_out, 2))
    else $error("selected without a processed event");
  AST_RESET_RELEASE: assert property (ev_valid_in && ev_ready_out && ev_reset_in |-> ##2 resp_bit_out)
    else $error("line not released after bus reset");
  AST_BUSY_MIN: assert property ($fell(nonvolatile_busy_flag_out) |-> busy_cnt_q >= NV_PROG_CYCLES + 6)
    else $error("busy flag cleared too early");
  AST_BUSY_MAX: assert property (nonvolatile_busy_flag_out |-> busy_cnt_q <= NV_PROG_CYCLES + 26)
    else $error("busy flag held too long");
  AST_BUSY_HOLD: assert property ($rose(nonvolatile_busy_flag_out) |=> nonvolatile_busy_flag_out [*8])
    else $error("busy flag pulse too short");
  AST_FULL_CAUSE: assert property ($fell(ev_ready_out) |-> $past(ev_valid_in))
    else $error("buffer full without a taken event");
  AST_FULL_RECOVER: assert property (!ev_ready_out |-> ##[1:30] ev_ready_out)
    else $error("buffer stays full past a copy burst");
  COV_BUSY: cover property ($rose(nonvolatile_busy_flag_out));
  COV_DESELECT: cover property ($fell(selected_out));
  COV_FULL: cover property (!ev_ready_out);
endmodule // osmc_core_chk
bind osmc_core osmc_core_chk #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) osmc_core_chk_inst (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ev_valid_in(ev_valid_in),
  .ev_reset_in(ev_reset_in), .ev_bit_in(ev_bit_in), .ev_ready_out(ev_ready_out),
  .resp_bit_out(resp_bit_out), .selected_out(selected_out),
  .nonvolatile_busy_flag_out(nonvolatile_busy_flag_out));
`default_nettype wire

/* File: osmc_master.sv */
// Slot layer model: offers bus resets and time slots one at a time
`default_nettype none
module osmc_master (
  input  wire logic mclk_in,
  input  wire logic ev_ready_in,
  input  wire logic resp_bit_in,
  output var logic  ev_valid_out,
  output var logic  ev_reset_out,
  output var logic  ev_bit_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ev_valid_out = 1'b0;
    ev_reset_out = 1'b0;
    ev_bit_out = 1'b0;
  end
  // Qualifiers scrambled once released so stale values never pass
  task automatic evt(input logic rst, input logic b);
    @(negedge mclk_in);
    ev_valid_out = 1'b1;
    ev_reset_out = rst;
    ev_bit_out = b;
    while (ev_ready_in !== 1'b1) @(negedge mclk_in);
    @(posedge mclk_in);
    @(negedge mclk_in);
    ev_valid_out = 1'b0;
    ev_reset_out = ~rst;
    ev_bit_out = ~b;
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic wbyte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      evt(1'b0, d[i]);
    end
  endtask
  // Pull-up: a lone device decides the line level
  task automatic rbit(output logic b);
    b = resp_bit_in;
    evt(1'b0, b);
  endtask
  task automatic rbyte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rbit(d[i]);
    end
  endtask
endmodule // osmc_master
`default_nettype wire

/* File: test_onewire_search_and_memory_cmds.sv */
// Self-checking bench for the search and memory command core
`default_nettype none
module test_onewire_search_and_memory_cmds;
  timeunit 1ns;
  timeprecision 100ps;
  import osmc_pkg::*;
  localparam logic [7:0]  FAM = 8'h3C; // Arbitrary value
  localparam logic [47:0] SER = 48'h00A1_B2C3_D4E5; // Arbitrary value
  logic mclk_in, reset_n_in, ev_valid, ev_reset, ev_bit;
  logic ev_ready, resp_bit, selected, busy, saw_full;
  logic [63:0] rom_id;
  int n_fail, n_tests, cyc;

  osmc_core #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER), .NV_PROG_CYCLES(20)) osmc_core_inst (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ev_valid_in(ev_valid),
    .ev_reset_in(ev_reset), .ev_bit_in(ev_bit), .ev_ready_out(ev_ready),
    .resp_bit_out(resp_bit), .selected_out(selected), .nonvolatile_busy_flag_out(busy));
  osmc_master osmc_master_inst (.mclk_in(mclk_in), .ev_ready_in(ev_ready),
    .resp_bit_in(resp_bit), .ev_valid_out(ev_valid), .ev_reset_out(ev_reset),
    .ev_bit_out(ev_bit));

  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Full search pass; a wrong direction at step bad drops the device
  task automatic sel(input int bad);
    logic a, b;
    osmc_master_inst.evt(1'b1, 1'b0);
    osmc_master_inst.wbyte(CMD_SEARCH);
    for (int i = 0; i < 64; i++) begin
      osmc_master_inst.rbit(a);
      osmc_master_inst.rbit(b);
      if (bad < 0 || i <= bad) begin
        chk(8'({a, b}), 8'({rom_id[i], ~rom_id[i]}));
      end else begin
        chk(8'({a, b}), 8'h03);
      end
      osmc_master_inst.evt(1'b0, rom_id[i] ^ (i == bad));
    end
    chk(8'(selected), 8'(bad < 0));
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] base, input int n);
    sel(-1);
    osmc_master_inst.wbyte(CMD_WR_SP);
    osmc_master_inst.wbyte(addr);
    for (int j = 0; j < n; j++) begin
      osmc_master_inst.wbyte(8'(base + j));
    end
  endtask
  task automatic rdchk(input logic [7:0] addr, input logic [7:0] base, input int nv);
    logic [7:0] r, e, c;
    c = 8'h00;
    sel(-1);
    osmc_master_inst.wbyte(CMD_RD_SP);
    osmc_master_inst.wbyte(addr);
    for (int j = int'(addr); j <= int'(addr | 8'h1F); j++) begin
      e = ((j % 32) < nv) ? 8'(base + j - addr) : ONES_BYTE;
      c = crc_byte(c, e);
      osmc_master_inst.rbyte(r);
      chk(r, e);
    end
    osmc_master_inst.rbyte(r);
    chk(r, c);
    osmc_master_inst.rbyte(r);
    chk(r, ONES_BYTE);
  endtask
  task automatic idle;
    for (int k = 0; k < 100 && busy !== 1'b0; k++) begin
      @(negedge mclk_in);
    end
    chk(8'(busy), 8'h00);
    repeat (4) @(negedge mclk_in);
  endtask
  task automatic t_passive;
    logic [7:0] r;
    sel(5);
    osmc_master_inst.wbyte(CMD_RD_SP);
    osmc_master_inst.wbyte(8'h00);
    osmc_master_inst.rbyte(r);
    chk(r, ONES_BYTE);
    osmc_master_inst.evt(1'b1, 1'b0);
    osmc_master_inst.wbyte(CMD_RD_SP);
    chk(8'(selected), 8'h00);
    osmc_master_inst.wbyte(8'h00);
    osmc_master_inst.rbyte(r);
    chk(r, ONES_BYTE);
    sel(-1);
    osmc_master_inst.wbyte(8'hB2);
    chk(8'(selected), 8'h00);
    // Start address past the last page drops the device
    sel(-1);
    osmc_master_inst.wbyte(CMD_RD_SP);
    osmc_master_inst.wbyte(8'h60);
    chk(8'(selected), 8'h00);
    osmc_master_inst.rbyte(r);
    chk(r, ONES_BYTE);
  endtask
  // Page-1 copy bursts last 24 cycles, page-2/3 bursts 8; slots sent during the first fill the buffer
  task automatic t_copy;
    wr(8'h00, 8'hA0, 32);
    sel(-1);
    osmc_master_inst.wbyte(CMD_SP1_NV1);
    chk(8'(busy), 8'h01);
    for (int k = 0; k < 3; k++) begin
      osmc_master_inst.evt(1'b0, 1'b1);
    end
    chk(8'(saw_full), 8'h01);
    idle;
    wr(8'h00, 8'h10, 24);
    sel(-1);
    osmc_master_inst.wbyte(CMD_NV1_SP1);
    repeat (26) @(negedge mclk_in);
    rdchk(8'h00, 8'hA0, 24);
    sel(-1);
    osmc_master_inst.wbyte(CMD_SP2_NV2);
    chk(8'(busy), 8'h01);
    idle;
    sel(-1);
    osmc_master_inst.wbyte(CMD_SP3_SRAM);
    chk(8'(busy), 8'h00);
    repeat (26) @(negedge mclk_in);
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(negedge mclk_in) begin
    cyc++;
    if (ev_ready === 1'b0) begin
      saw_full = 1'b1;
    end
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    logic [7:0] c;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    saw_full = 1'b0;
    reset_n_in = 1'b0;
    c = crc_byte(8'h00, FAM);
    for (int k = 0; k < 6; k++) begin
      c = crc_byte(c, SER[8*k +: 8]);
    end
    rom_id = {c, SER, FAM};
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    chk(8'({ev_ready, resp_bit, selected, busy}), 8'h0C);
    reset_n_in = 1'b1;
    t_passive;
    wr(8'h44, 8'h61, 30);
    rdchk(8'h44, 8'h61, 8);
    t_copy;
    end_sim();
  end
endmodule // test_onewire_search_and_memory_cmds
`default_nettype wire
